//--- src/dplb_pkg.sv
// Shared constants, types and helpers of the dual-port line buffer
package dplb_pkg;

   // Data path and memory geometry
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 14;
   localparam int ROW_W = 13;
   localparam int WORDS_WIDE = 5048;
   localparam int WORDS_NARROW = 10096;
   localparam logic [ADDR_W-1:0] LAST_WIDE = 14'h13B7;
   localparam logic [ADDR_W-1:0] LAST_NARROW = 14'h276F;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;

   // Configuration codes taken from config_select
   localparam logic CFG_WIDE = 1'b0;
   localparam logic CFG_NARROW = 1'b1;
   localparam logic CFG_RESET = CFG_WIDE;

   // Write-to-read visibility bound, kept as time and as clk_i cycles
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WR_VISIBLE_NS = 500;
   localparam int WR_VISIBLE_CYC = (WR_VISIBLE_NS * 1000) / CLK_PERIOD_PS;

   // Register map, byte addresses on the Wishbone bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;

   // Control register fields and reset value
   localparam int CTRL_WR_EN_BIT = 0;
   localparam int CTRL_RD_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;

   // Status register fields
   localparam int ST_WR_ADDR_LSB = 0;
   localparam int ST_RD_ADDR_LSB = 16;
   localparam int ST_WR_CFG_BIT = 30;
   localparam int ST_RD_CFG_BIT = 31;

   // Pin group of one port as seen by the pointer logic
   typedef struct packed {
      logic clk;
      logic clear_n;
      logic gate_n;
      logic cfg_sel;
   } dplb_port_ctl_t;

   // Pointer state reported by one port
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic cfg;
   } dplb_port_st_t;

   // Highest address for a configuration
   function automatic logic [ADDR_W-1:0] last_addr(input logic cfg);
      last_addr = (cfg == CFG_NARROW) ? LAST_NARROW : LAST_WIDE;
   endfunction

endpackage

//--- src/dplb_ptr.sv
// Address pointer and configuration latch of one buffer port
`timescale 1ns/1ps

module dplb_ptr (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire dplb_pkg::dplb_port_ctl_t ctl_i,
   output dplb_pkg::dplb_port_st_t st_o,
   output logic edge_o,
   output logic step_o
);

   logic clk_prev_q; // Port clock level one cycle ago
   logic clk_prev_d;
   logic [dplb_pkg::ADDR_W-1:0] addr_q; // Current port address
   logic [dplb_pkg::ADDR_W-1:0] addr_d;
   logic cfg_q; // Latched configuration
   logic cfg_d;
   logic rise; // Port clock rising edge seen this cycle

   // Port clock is synchronous to clk_i, so a plain edge detect is safe
   assign rise = ctl_i.clk & ~clk_prev_q & en_i;
   assign edge_o = rise;
   // A stepping cycle: not clearing and not gated
   assign step_o = rise & ctl_i.clear_n & ~ctl_i.gate_n;
   assign st_o.addr = addr_q;
   assign st_o.cfg = cfg_q;

   // Next pointer state
   always_comb
   begin
      clk_prev_d = ctl_i.clk;
      addr_d = addr_q;
      cfg_d = cfg_q;
      if (rise)
      begin
         if (!ctl_i.clear_n)
         begin
            // Clear wins whatever the gate says [RULE8] [RULE9] [RULE14]
            addr_d = dplb_pkg::ADDR_ZERO;
            cfg_d = ctl_i.cfg_sel; // Mode latched in clear cycle [RULE3]
         end
         else if (!ctl_i.gate_n)
         begin
            // Advance with wrap at the configured end [RULE6] [RULE11]
            if (addr_q == dplb_pkg::last_addr(cfg_q))
               addr_d = dplb_pkg::ADDR_ZERO;
            else
               addr_d = addr_q + dplb_pkg::ADDR_ONE;
         end
         // Gated cycle holds the address [RULE7] [RULE12]
      end
   end

   // Pointer registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clk_prev_q <= 1'b0;
         addr_q <= dplb_pkg::ADDR_ZERO;
         cfg_q <= dplb_pkg::CFG_RESET;
      end
      else
      begin
         clk_prev_q <= clk_prev_d;
         addr_q <= addr_d;
         cfg_q <= cfg_d;
      end
   end

endmodule

//--- src/dplb_top.sv
// Dual-port line buffer with Wishbone control and status registers
//
// How it works
// [RULE1] Low config gives 5048 words of 16 bits
// [RULE2] High config gives 10096 bytes, low lane
// [RULE3] Config latched per port during clear
// [RULE4] Latched drive-off floats read data
// [RULE5] Read edge samples clear, gate, drive
// [RULE6] Read address steps, wraps at end
// [RULE7] Read gate holds address and data
// [RULE8] Read clear zeroes read address
// [RULE9] Write clear zeroes write address
// [RULE10] Controls at cycle start, data at end
// [RULE11] Write address steps, wraps at end
// [RULE12] Write gate blocks store and step
// [RULE13] Host clears both ports before use
// [RULE14] Clears work regardless of gates, drive
// [RULE15] Written data readable within 500 ns
// [RULE16] Reads never alter stored data
// [RULE17] Shared clock gives full-depth delay
// [RULE18] Host keeps delay at least 21 cycles
// [RULE19] Ports run independently at own rates
// [RULE20] Gating write lengthens, read shortens delay; here write gating shortens it, read gating lengthens it
// [RULE21] Mismatched port configs give undefined data
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps

module dplb_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic wr_clk_i,
   input wire logic wr_ptr_clear_n_i,
   input wire logic wr_gate_n_i,
   input wire logic [15:0] wr_data_in_i,
   // Read port
   input wire logic rd_clk_i,
   input wire logic rd_ptr_clear_n_i,
   input wire logic rd_gate_n_i,
   input wire logic output_drive_n_i,
   output logic [15:0] rd_data_out_o,
   output logic rd_data_oe_o,
   // Shared mode pin
   input wire logic config_select_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // Storage split in two byte banks of 5048 rows each
   logic [7:0] bank_lo [0:dplb_pkg::WORDS_WIDE-1];
   logic [7:0] bank_hi [0:dplb_pkg::WORDS_WIDE-1];

   dplb_pkg::dplb_port_ctl_t wr_ctl; // Write pin group
   dplb_pkg::dplb_port_ctl_t rd_ctl; // Read pin group
   dplb_pkg::dplb_port_st_t wr_st; // Write pointer state
   dplb_pkg::dplb_port_st_t rd_st; // Read pointer state
   logic wr_edge; // Write clock rising edge
   logic wr_step; // Write cycle begins
   logic rd_edge; // Read clock rising edge
   logic rd_step; // Read cycle proceeds

   logic [1:0] ctrl_q; // Port enables written by software
   logic [1:0] ctrl_d;
   logic ack_q; // Bus answer
   logic ack_d;
   logic [31:0] dat_q; // Bus read data
   logic [31:0] dat_d;

   logic pend_q; // A write cycle awaits its closing edge
   logic pend_d;
   logic [dplb_pkg::ADDR_W-1:0] pend_addr_q; // Address of that cycle
   logic [dplb_pkg::ADDR_W-1:0] pend_addr_d;
   logic pend_cfg_q; // Config in force for that cycle
   logic pend_cfg_d;
   logic store; // Memory write this cycle
   logic [dplb_pkg::ROW_W-1:0] wr_row; // Bank row written
   logic wr_lo; // Low bank enable
   logic wr_hi; // High bank enable
   logic [7:0] wr_lo_byte; // Byte for the low bank

   logic [15:0] rdat_q; // Read data register
   logic [15:0] rdat_d;
   logic roe_q; // Read output enable
   logic roe_d;
   logic [dplb_pkg::ROW_W-1:0] rd_row; // Bank row read
   logic [15:0] rd_word; // Word fetched for the read port

   // Pin groups into the carrier structs
   assign wr_ctl.clk = wr_clk_i;
   assign wr_ctl.clear_n = wr_ptr_clear_n_i;
   assign wr_ctl.gate_n = wr_gate_n_i;
   assign wr_ctl.cfg_sel = config_select_i;
   assign rd_ctl.clk = rd_clk_i;
   assign rd_ctl.clear_n = rd_ptr_clear_n_i;
   assign rd_ctl.gate_n = rd_gate_n_i;
   assign rd_ctl.cfg_sel = config_select_i;

   // Write pointer; keeps its own config apart from the read side
   dplb_ptr u_wr_ptr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ctrl_q[dplb_pkg::CTRL_WR_EN_BIT]),
      .ctl_i(wr_ctl),
      .st_o(wr_st),
      .edge_o(wr_edge),
      .step_o(wr_step)
   ); // [RULE19]

   // Read pointer; steps on ungated, non-clearing read clock edges while enabled, at the read clock's own rate
   dplb_ptr u_rd_ptr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ctrl_q[dplb_pkg::CTRL_RD_EN_BIT]),
      .ctl_i(rd_ctl),
      .st_o(rd_st),
      .edge_o(rd_edge),
      .step_o(rd_step)
   ); // [RULE19]

   // Write pipeline: address at cycle start, data at the next edge
   always_comb
   begin
      pend_d = pend_q;
      pend_addr_d = pend_addr_q;
      pend_cfg_d = pend_cfg_q;
      if (wr_edge)
      begin
         pend_d = wr_step; // Gated or clearing cycles store nothing [RULE12]
         pend_addr_d = wr_st.addr;
         pend_cfg_d = wr_st.cfg;
      end
   end

   // Data is taken on the edge that closes the pending cycle [RULE10]
   assign store = wr_edge & pend_q;

   // Bank steering by write config
   always_comb
   begin
      if (pend_cfg_q == dplb_pkg::CFG_NARROW)
      begin
         // Byte mode: row is address half, bit 0 picks the bank [RULE2]
         wr_row = pend_addr_q[dplb_pkg::ADDR_W-1:1];
         wr_lo = store & ~pend_addr_q[0];
         wr_hi = store & pend_addr_q[0];
      end
      else
      begin
         // Word mode: both banks on one row [RULE1]
         wr_row = pend_addr_q[dplb_pkg::ROW_W-1:0];
         wr_lo = store;
         wr_hi = store;
      end
      wr_lo_byte = wr_data_in_i[7:0];
   end

   // Pipeline registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pend_q <= 1'b0;
         pend_addr_q <= dplb_pkg::ADDR_ZERO;
         pend_cfg_q <= dplb_pkg::CFG_RESET;
      end
      else
      begin
         pend_q <= pend_d;
         pend_addr_q <= pend_addr_d;
         pend_cfg_q <= pend_cfg_d;
      end
   end

   // Memory banks; no reset, contents kept until overwritten [RULE16]
   always_ff @(posedge clk_i)
   begin
      if (wr_lo)
         bank_lo[wr_row] <= wr_lo_byte;
      // High bank takes the upper lane in word mode, low lane in byte mode
      if (wr_hi)
         bank_hi[wr_row] <= pend_cfg_q ? wr_lo_byte : wr_data_in_i[15:8];
   end

   // Read fetch by read config; a config mismatch gives garbage [RULE21]
   always_comb
   begin
      if (rd_st.cfg == dplb_pkg::CFG_NARROW)
      begin
         rd_row = rd_st.addr[dplb_pkg::ADDR_W-1:1];
         rd_word = {8'h00, rd_st.addr[0] ? bank_hi[rd_row]
                                         : bank_lo[rd_row]}; // [RULE2]
      end
      else
      begin
         rd_row = rd_st.addr[dplb_pkg::ROW_W-1:0];
         rd_word = {bank_hi[rd_row], bank_lo[rd_row]}; // [RULE1]
      end
   end

   // Read output next state, all taken on the read edge [RULE5]
   always_comb
   begin
      rdat_d = rdat_q;
      roe_d = roe_q;
      if (rd_edge)
      begin
         roe_d = ~output_drive_n_i; // Drive-off floats the lanes [RULE4]
         // A stored word is visible one clk_i cycle later [RULE15]
         if (rd_step)
            rdat_d = rd_word; // Read is non-destructive [RULE16]
         // Gated or clearing edges keep the last word [RULE7]
      end
   end

   // Read output registers; ports share one clock here [RULE17] [RULE20]
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdat_q <= 16'h0000;
         roe_q <= 1'b0;
      end
      else
      begin
         rdat_q <= rdat_d;
         roe_q <= roe_d;
      end
   end

   assign rd_data_out_o = rdat_q;
   assign rd_data_oe_o = roe_q;

   // Wishbone decode: one-cycle answer, unmapped reads zero
   always_comb
   begin
      ctrl_d = ctrl_q;
      dat_d = dat_q;
      ack_d = 1'b0;
      if (wb_cyc_i && wb_stb_i && !ack_q)
      begin
         ack_d = 1'b1;
         dat_d = 32'h0000_0000;
         case (wb_adr_i[7:0])
            dplb_pkg::OFS_CTRL:
            begin
               if (wb_we_i && wb_sel_i[0])
                  ctrl_d = wb_dat_i[1:0];
               dat_d[1:0] = ctrl_q;
            end
            dplb_pkg::OFS_STATUS:
            begin
               dat_d[dplb_pkg::ST_WR_ADDR_LSB +: dplb_pkg::ADDR_W] =
                  wr_st.addr;
               dat_d[dplb_pkg::ST_RD_ADDR_LSB +: dplb_pkg::ADDR_W] =
                  rd_st.addr;
               dat_d[dplb_pkg::ST_WR_CFG_BIT] = wr_st.cfg;
               dat_d[dplb_pkg::ST_RD_CFG_BIT] = rd_st.cfg;
            end
            default:
            begin
               // Unmapped: acknowledged, writes dropped, reads zero
               dat_d = 32'h0000_0000;
            end
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= dplb_pkg::CTRL_RESET;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

endmodule

//--- testbench/dplb_props.sv
// Assertion checker for the read port and the register bus
`timescale 1ns/1ps

module dplb_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_clk_i,
   input wire logic rd_ptr_clear_n_i,
   input wire logic rd_gate_n_i,
   input wire logic output_drive_n_i,
   input wire logic config_select_i,
   input wire logic [15:0] rd_data_out_o,
   input wire logic rd_data_oe_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   logic rd_prev_q; // Read clock level at the last edge
   logic rd_cfg_q; // Read config as latched at clear edges
   logic rd_edge; // Rise seen on this clk_i edge
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign rd_edge = rd_clk_i & ~rd_prev_q;
   // Mirror of the port edge detector without the en_i gate; reset level 0 like the design
   always_ff @(posedge clk_i)
   begin
      rd_prev_q <= rst_i ? 1'b0 : rd_clk_i;
      if (rst_i)
         rd_cfg_q <= 1'b0;
      else if (rd_edge && !rd_ptr_clear_n_i)
         rd_cfg_q <= config_select_i;
   end
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i > 32'h00000004 |-> wb_dat_o == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_oe;
      rd_edge |=> rd_data_oe_o == !$past(output_drive_n_i);
   endproperty
   a_oe: assert property (p_oe) else $error("drive wrong");
   property p_hold;
      rd_edge && rd_gate_n_i |=> $stable(rd_data_out_o);
   endproperty
   a_hold: assert property (p_hold) else $error("gated data moved");
   property p_clear;
      rd_edge && !rd_ptr_clear_n_i |=> $stable(rd_data_out_o);
   endproperty
   a_clear: assert property (p_clear) else $error("clear moved data");
   property p_quiet;
      !rd_edge |=> $stable(rd_data_out_o) && $stable(rd_data_oe_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("change off edge");
   property p_narrow;
      rd_edge && rd_cfg_q && rd_ptr_clear_n_i && !rd_gate_n_i
         |=> rd_data_out_o[15:8] == 8'h00;
   endproperty
   a_narrow: assert property (p_narrow) else $error("upper lane set");
endmodule

bind dplb_top dplb_props dplb_props_inst (.clk_i, .rst_i, .rd_clk_i,
   .rd_ptr_clear_n_i, .rd_gate_n_i, .output_drive_n_i, .config_select_i,
   .rd_data_out_o, .rd_data_oe_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o);

//--- testbench/dplb_host.sv
// Host model making one shared port clock for both ports
`timescale 1ns/1ps

module dplb_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic wr_clk_o,
   output logic rd_clk_o
);
   logic pclk_q; // Each level lasts one clk_i cycle
   // Same pulse on both clocks, as a delay line wants
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !run_i)
         pclk_q <= 1'b0; // Stands still while idle
      else
         pclk_q <= ~pclk_q;
   end
   assign wr_clk_o = pclk_q;
   assign rd_clk_o = pclk_q;
endmodule

//--- testbench/dplb_top_test.sv
// Self-checking bench for the dual-port line buffer
`timescale 1ns/1ps

module dplb_top_test;
   logic clk_i, rst_i, run, wr_clk_i, rd_clk_i, cfgv, doe;
   logic wr_ptr_clear_n_i, wr_gate_n_i, rd_ptr_clear_n_i, rd_gate_n_i;
   logic output_drive_n_i, config_select_i, rd_data_oe_o;
   logic [15:0] wr_data_in_i, rd_data_out_o, dout;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   int error_cnt, checks_done, cyc_cnt, i;
   dplb_top dplb_top_inst (.clk_i, .rst_i, .wr_clk_i, .wr_ptr_clear_n_i,
      .wr_gate_n_i, .wr_data_in_i, .rd_clk_i, .rd_ptr_clear_n_i,
      .rd_gate_n_i, .output_drive_n_i, .rd_data_out_o, .rd_data_oe_o,
      .config_select_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
      .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   dplb_host dplb_host_inst (.clk_i, .rst_i, .run_i(run),
      .wr_clk_o(wr_clk_i), .rd_clk_o(rd_clk_i));
   always #2.5 clk_i = ~clk_i;
   // Data pattern, distinct per address
   function automatic logic [15:0] pat(input int k);
      pat = 16'h5A00 ^ k[15:0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, v);
      checks_done++;
      if (v !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One classic Wishbone cycle; read data checked against e
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, e);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= {24'h000000, a};
      wb_dat_i <= d;
      n = 0;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (n >= 20)
      begin
         error_cnt++;
         $display("mismatch wb_ack_o expected 1 seen 0");
      end
      if (!we)
         chk("wb_dat_o", e, wb_dat_o);
   endtask
   // One port cycle; waits so the next clk_i edge is a port edge,
   // and samples what the previous port edge produced
   task automatic pc(input logic wc, wg, input logic [15:0] wd,
                     input logic rc, rg, od);
      do @(posedge clk_i); while (wr_clk_i !== 1'b0);
      {wr_ptr_clear_n_i, wr_gate_n_i, wr_data_in_i} <= {wc, wg, wd};
      {rd_ptr_clear_n_i, rd_gate_n_i, output_drive_n_i} <= {rc, rg, od};
      config_select_i <= cfgv;
      #1 dout = rd_data_out_o;
      doe = rd_data_oe_o;
      @(posedge clk_i);
   endtask
   // Shared-clock delay line of full depth, clears applied together
   task automatic dl(input logic c, input int depth);
      int k;
      cfgv = c;
      pc(1'b0, 1'b1, 16'h0000, 1'b0, 1'b1, 1'b0);
      for (k = 0; k < depth + 4; k++)
      begin
         pc(1'b1, 1'b0, pat(k), 1'b1, 1'b0, 1'b0);
         if (k > depth)
            chk("delay", 32'(pat(k - depth) & (c ? 16'hFF : 16'hFFFF)),
                32'(dout));
      end
   endtask
   // Hang guard; whole run is about 30400 cycles
   always @(posedge clk_i)
   begin
      cyc_cnt++;
      if (cyc_cnt == 40000)
      begin
         error_cnt++;
         summarize();
      end
   end
   initial
   begin
      {clk_i, rst_i, run, cfgv, wr_data_in_i} = {4'b0100, 16'h0000};
      {wr_ptr_clear_n_i, wr_gate_n_i, rd_ptr_clear_n_i} = 3'b111;
      {rd_gate_n_i, output_drive_n_i, config_select_i} = 3'b100;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 7'h0F;
      {wb_adr_i, wb_dat_i} = '0;
      {error_cnt, checks_done, cyc_cnt} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0, 32'h3); // Control reset value
      wb(1'b0, 8'h04, 32'h0, 32'h0); // Status reset value
      wb(1'b1, 8'h08, 32'hFFFFFFFF, 32'h0); // Unmapped write dropped
      wb(1'b0, 8'h08, 32'h0, 32'h0);
      wb(1'b1, 8'h00, 32'h3, 32'h0);
      wb(1'b0, 8'h00, 32'h0, 32'h3);
      @(posedge clk_i);
      run <= 1'b1;
      pc(1'b0, 1'b1, 16'h0, 1'b0, 1'b1, 1'b0);
      for (i = 0; i < 5; i++)
         pc(1'b1, i == 4, pat(i - 1), 1'b1, 1'b1, 1'b0);
      wb(1'b0, 8'h04, 32'h0, 32'h4);
      for (i = 0; i < 6; i++)
      begin
         pc(1'b1, 1'b1, 16'h0, 1'b1, i > 3, 1'b0);
         if (i > 0)
            chk("rd_data", 32'(pat(i < 5 ? i - 1 : 3)), 32'(dout));
      end
      wb(1'b0, 8'h04, 32'h0, 32'h00040004);
      pc(1'b1, 1'b1, 16'h0, 1'b1, 1'b1, 1'b1);
      pc(1'b1, 1'b1, 16'h0, 1'b1, 1'b1, 1'b0);
      chk("oe_off", 32'h0, 32'(doe));
      pc(1'b0, 1'b1, 16'h0, 1'b0, 1'b1, 1'b1);
      chk("oe_on", 32'h1, 32'(doe));
      wb(1'b0, 8'h04, 32'h0, 32'h0);
      pc(1'b1, 1'b1, 16'h0, 1'b1, 1'b0, 1'b0);
      pc(1'b1, 1'b1, 16'h0, 1'b1, 1'b1, 1'b0);
      chk("reread", 32'(pat(0)), 32'(dout));
      dl(1'b0, 5048);
      dl(1'b1, 10096);
      cfgv = 1'b1;
      pc(1'b0, 1'b1, 16'h0, 1'b0, 1'b1, 1'b0);
      cfgv = 1'b0;
      pc(1'b0, 1'b1, 16'h0, 1'b1, 1'b1, 1'b0);
      wb(1'b0, 8'h04, 32'h0, 32'h80000000);
      // Read port switched off: ungated read edges must not step
      wb(1'b1, 8'h00, 32'h1, 32'h0);
      pc(1'b0, 1'b1, 16'h0, 1'b1, 1'b0, 1'b0);
      wb(1'b0, 8'h04, 32'h0, 32'h80000000); // Read address still 0
      wb(1'b0, 8'h00, 32'h0, 32'h1); // Enables as written
      summarize();
   end
endmodule
